// ---- crp_pkg.sv ----
// Package for the register pointing and status flag block
package crp_pkg;
  localparam logic [7:0] low_pointer_offset  = 8'he8;
  localparam logic [7:0] high_pointer_offset = 8'he9;
  localparam logic [7:0] page_select_offset  = 8'hea;
  localparam logic [7:0] flag_offset         = 8'he7;
  localparam logic [3:0] group_d             = 4'hd;
  localparam logic [3:0] group_f             = 4'hf;
  localparam int         block_lsb           = 3;
  localparam int         twin_bit            = 2;
  localparam int         page_lsb            = 2;
  localparam logic [1:0] low_bits_reset      = 2'h0;
  localparam logic [5:0] upper_bits_reset    = 6'h00;
  localparam int         flag_sign_bit       = 5;
  localparam int         flag_ovf_bit        = 4;
  localparam int         flag_bcd_bit        = 3;
  localparam int         flag_half_bit       = 2;
  localparam int         flag_space_bit      = 0;

  typedef enum logic [7:0] {
    crp_op_none      = 8'h01,
    crp_op_add       = 8'h02,
    crp_op_sub       = 8'h04,
    crp_op_logic     = 8'h08,
    crp_op_bcd       = 8'h10,
    crp_op_set_data  = 8'h20,
    crp_op_set_code  = 8'h40,
    crp_op_other     = 8'h80
  } crp_op_type;

  typedef enum logic [2:0] {
    crp_ptr_single = 3'h1,
    crp_ptr_low    = 3'h2,
    crp_ptr_high   = 3'h4
  } crp_ptr_cmd_type;
endpackage

// ---- crp_alu_if.sv ----
// Interface carrying the flag unit request and result
`timescale 1ns/1ps
interface crp_alu_if;
  import crp_pkg::*;
  logic             valid;
  crp_op_type       op;
  logic             word;
  logic [15:0]      a;
  logic [15:0]      b;
  logic             carry_in;
  logic [15:0]      result;
  logic             sign;
  logic             ovf;
  logic             half;
  logic             bcd_carry;
  logic             upd_zero_set;
  modport core (output valid, op, word, a, b, carry_in,
                input result, sign, ovf, half, bcd_carry, upd_zero_set);
  modport unit (input valid, op, word, a, b, carry_in,
                output result, sign, ovf, half, bcd_carry, upd_zero_set);
endinterface

// ---- crp_alu.sv ----
// Combinational arithmetic and flag evaluation
`timescale 1ns/1ps
module crp_alu
  import crp_pkg::*;
(
  crp_alu_if.unit   alu,
  input wire logic  i_bcd_sub,
  input wire logic  i_half_in
);
  logic [16:0] sum;
  logic [7:0]  adj;
  logic        msb_a;
  logic        msb_b;
  logic        msb_r;
  logic [4:0]  nib;

  always_comb
  begin
    sum       = 17'h00000;
    adj       = 8'h00;
    nib       = 5'h00;
    alu.bcd_carry = 1'b0;
    unique case (alu.op)
      crp_op_add:
      begin
        sum = {1'b0, alu.a} + {1'b0, alu.b} + {16'h0000, alu.carry_in};
        nib = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]} + {4'h0, alu.carry_in};
      end
      crp_op_sub:
      begin
        sum = {1'b0, alu.a} - {1'b0, alu.b} - {16'h0000, alu.carry_in};
        nib = {1'b0, alu.a[3:0]} - {1'b0, alu.b[3:0]} - {4'h0, alu.carry_in};
      end
      crp_op_logic:
        sum = {1'b0, alu.a & alu.b};
      crp_op_bcd:
      begin
        if (i_half_in || alu.a[3:0] > 4'h9)
          adj[3:0] = 4'h6;
        if (alu.carry_in || alu.a[7:0] > 8'h99)
        begin
          adj[7:4] = 4'h6;
          alu.bcd_carry = 1'b1;
        end
        if (i_bcd_sub)
          sum = {9'h000, alu.a[7:0] - adj};
        else
          sum = {9'h000, alu.a[7:0] + adj};
      end
      default:
        sum = {1'b0, alu.a};
    endcase
  end

  assign alu.result = alu.word ? sum[15:0] : {8'h00, sum[7:0]};
  assign msb_a = alu.word ? alu.a[15] : alu.a[7];
  assign msb_b = alu.word ? alu.b[15] : alu.b[7];
  assign msb_r = alu.word ? sum[15] : sum[7];
  assign alu.sign = msb_r;
  assign alu.ovf = (alu.op == crp_op_add) ? (msb_a == msb_b) && (msb_r != msb_a) :
                   (alu.op == crp_op_sub) ? (msb_a != msb_b) && (msb_r != msb_a) : 1'b0;
  assign alu.half = nib[4];
  assign alu.upd_zero_set = alu.valid &&
    (alu.op inside {crp_op_add, crp_op_sub, crp_op_logic, crp_op_bcd, crp_op_other});
endmodule

// ---- crp_core.sv ----
// Register pointing, page select and arithmetic status flags
`timescale 1ns/1ps
module crp_core
  import crp_pkg::*;
(
  input  wire logic                 i_clock,
  input  wire logic                 i_nrst,
  input  wire logic                 i_op_valid,
  input  wire crp_pkg::crp_op_type  i_op,
  input  wire logic                 i_op_word,
  input  wire logic [15:0]          i_op_a,
  input  wire logic [15:0]          i_op_b,
  input  wire logic                 i_carry_in,
  output logic [15:0]               o_result,
  output logic                      o_bcd_carry,
  input  wire logic                 i_ptr_valid,
  input  wire crp_pkg::crp_ptr_cmd_type i_ptr_cmd,
  input  wire logic [4:0]           i_block_index,
  input  wire logic                 i_page_valid,
  input  wire logic [5:0]           i_page_index,
  input  wire logic                 i_reg_wr,
  input  wire logic [7:0]           i_reg_addr,
  input  wire logic [7:0]           i_reg_wdata,
  input  wire logic                 i_reg_direct,
  output logic [7:0]                o_reg_rdata,
  output logic                      o_reg_error,
  input  wire logic [3:0]           i_work_index,
  output logic [7:0]                o_work_addr,
  input  wire logic                 i_data_access,
  output logic                      o_use_data_pointers,
  output logic [5:0]                o_page_index,
  output logic [7:0]                o_flags
);
  import crp_pkg::*;

  logic       rst_meta;
  logic       rst_sync;
  logic [4:0] low_block;
  logic [4:0] high_block;
  logic       twin_mode_select;
  logic [5:0] page_index;
  logic       sign_flag;
  logic       ovf_flag;
  logic       bcd_op_kind_bit;
  logic       half_flag;
  logic       memory_space_select;
  logic [7:0] working_window_low_pointer;
  logic [7:0] working_window_high_pointer;
  logic [7:0] peripheral_page_select;
  logic [7:0] next_work_addr;

  crp_alu_if alu_bus();

  always_ff @(posedge i_clock or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign alu_bus.valid    = i_op_valid;
  assign alu_bus.op       = i_op;
  assign alu_bus.word     = i_op_word;
  assign alu_bus.a        = i_op_a;
  assign alu_bus.b        = i_op_b;
  assign alu_bus.carry_in = i_carry_in;

  crp_alu u_alu (
    .alu       (alu_bus.unit),
    .i_bcd_sub (bcd_op_kind_bit),
    .i_half_in (half_flag)
  );

  function automatic logic is_reg(input logic [7:0] addr, input logic [7:0] off);
    is_reg = i_reg_wr && (addr == off);
  endfunction

  always_ff @(posedge i_clock or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      o_result    <= 16'h0000;
      o_bcd_carry <= 1'b0;
    end
    else if (i_op_valid)
    begin
      o_result    <= alu_bus.result;
      o_bcd_carry <= alu_bus.bcd_carry;
    end
  end

  // Arithmetic flags; an instruction update wins over a register write
  always_ff @(posedge i_clock or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      sign_flag       <= 1'b0;
      ovf_flag        <= 1'b0;
      bcd_op_kind_bit <= 1'b0;
      half_flag       <= 1'b0;
    end
    else
    begin
      if (is_reg(i_reg_addr, flag_offset))
      begin
        sign_flag       <= i_reg_wdata[flag_sign_bit];
        ovf_flag        <= i_reg_wdata[flag_ovf_bit];
        bcd_op_kind_bit <= i_reg_wdata[flag_bcd_bit];
        half_flag       <= i_reg_wdata[flag_half_bit];
      end
      if (alu_bus.upd_zero_set)
      begin
        sign_flag <= alu_bus.sign;
        ovf_flag  <= alu_bus.ovf;
      end
      if (i_op_valid && (i_op == crp_op_add || i_op == crp_op_sub))
      begin
        bcd_op_kind_bit <= (i_op == crp_op_sub);
        if (!i_op_word)
          half_flag <= alu_bus.half;
      end
    end
  end

  always_ff @(posedge i_clock or negedge rst_sync)
  begin
    if (!rst_sync)
      memory_space_select <= 1'b0;
    else if (i_op_valid && i_op == crp_op_set_data)
      memory_space_select <= 1'b1;
    else if (i_op_valid && i_op == crp_op_set_code)
      memory_space_select <= 1'b0;
    else if (is_reg(i_reg_addr, flag_offset))
      memory_space_select <= i_reg_wdata[flag_space_bit];
  end

  // Data pointers only for data accesses
  assign o_use_data_pointers = i_data_access && memory_space_select;

  assign o_flags = {2'h0, sign_flag, ovf_flag, bcd_op_kind_bit, half_flag, 1'b0,
                    memory_space_select};

  // Upper bits are undefined after reset; zero is chosen so outputs stay known
  // Pointer commands and twin bit
  always_ff @(posedge i_clock or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      low_block        <= upper_bits_reset[4:0];
      high_block       <= upper_bits_reset[4:0];
      twin_mode_select <= upper_bits_reset[0];
    end
    else if (i_ptr_valid)
    begin
      unique case (i_ptr_cmd)
        crp_ptr_single:
        begin
          low_block        <= {i_block_index[4:1], 1'b0};
          twin_mode_select <= 1'b0;
        end
        crp_ptr_low:
        begin
          low_block        <= i_block_index;
          twin_mode_select <= 1'b1;
        end
        crp_ptr_high:
        begin
          high_block       <= i_block_index;
          twin_mode_select <= 1'b1;
        end
        default:
          twin_mode_select <= twin_mode_select;
      endcase
    end
    else if (is_reg(i_reg_addr, low_pointer_offset))
    begin
      low_block        <= i_reg_wdata[7:block_lsb];
      twin_mode_select <= i_reg_wdata[twin_bit];
    end
    else if (is_reg(i_reg_addr, high_pointer_offset))
    begin
      high_block       <= i_reg_wdata[7:block_lsb];
      twin_mode_select <= i_reg_wdata[twin_bit];
    end
  end

  always_ff @(posedge i_clock or negedge rst_sync)
  begin
    if (!rst_sync)
      page_index <= upper_bits_reset;
    else if (i_page_valid)
      page_index <= i_page_index;
    else if (is_reg(i_reg_addr, page_select_offset))
      page_index <= i_reg_wdata[7:page_lsb];
  end

  // Pointer layout with zero low bits
  assign working_window_low_pointer  = {low_block, twin_mode_select, low_bits_reset};
  assign working_window_high_pointer = {high_block, twin_mode_select, low_bits_reset};
  assign peripheral_page_select      = {page_index, low_bits_reset};
  assign o_page_index = page_index;

  always_comb
  begin
    next_work_addr = 8'h00;
    if (!twin_mode_select)
      next_work_addr = {low_block[4:1], i_work_index};
    else if (!i_work_index[3])
      next_work_addr = {low_block, i_work_index[2:0]};
    else
      next_work_addr = {high_block, i_work_index[2:0]};
  end

  always_ff @(posedge i_clock or negedge rst_sync)
  begin
    if (!rst_sync)
      o_work_addr <= 8'h00;
    else
      o_work_addr <= next_work_addr;
  end

  // Refuse direct access to group D
  always_ff @(posedge i_clock or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      o_reg_rdata <= 8'h00;
      o_reg_error <= 1'b0;
    end
    else
    begin
      o_reg_error <= i_reg_direct && (i_reg_addr[7:4] == group_d);
      unique case (i_reg_addr)
        low_pointer_offset:  o_reg_rdata <= working_window_low_pointer;
        high_pointer_offset: o_reg_rdata <= working_window_high_pointer;
        page_select_offset:  o_reg_rdata <= peripheral_page_select;
        flag_offset:         o_reg_rdata <= o_flags;
        default:             o_reg_rdata <= 8'h00;
      endcase
    end
  end

  a_sign_byte: assert property (@(posedge i_clock) disable iff (!rst_sync)
    (i_op_valid && i_op == crp_op_add && !i_op_word) |=> sign_flag == o_result[7])
    else $error("sign flag does not follow bit 7");
  a_ovf_add: assert property (@(posedge i_clock) disable iff (!rst_sync)
    (i_op_valid && i_op == crp_op_add && !i_op_word && !i_op_a[7] && !i_op_b[7])
    |=> ovf_flag == o_result[7])
    else $error("overflow wrong on positive add");
  a_kind_sub: assert property (@(posedge i_clock) disable iff (!rst_sync)
    (i_op_valid && i_op == crp_op_sub) |=> bcd_op_kind_bit)
    else $error("kind bit not set on subtract");
  a_space_set: assert property (@(posedge i_clock) disable iff (!rst_sync)
    (i_op_valid && i_op == crp_op_set_data) |=> memory_space_select)
    else $error("space select not set");
  a_flag_reserved: assert property (@(posedge i_clock) disable iff (!rst_sync)
    o_flags[1] == 1'b0)
    else $error("reserved flag bit set");
  a_single_even: assert property (@(posedge i_clock) disable iff (!rst_sync)
    (i_ptr_valid && i_ptr_cmd == crp_ptr_single)
    |=> !twin_mode_select && low_block == {$past(i_block_index[4:1]), 1'b0})
    else $error("single window not even");
  a_twin_map: assert property (@(posedge i_clock) disable iff (!rst_sync)
    (twin_mode_select && i_work_index[3] && !i_ptr_valid && !i_reg_wr)
    |=> o_work_addr[7:3] == high_block)
    else $error("upper half not from high pointer");
  a_page_low: assert property (@(posedge i_clock) disable iff (!rst_sync)
    (i_page_valid) |=> o_page_index == $past(i_page_index) &&
    peripheral_page_select[1:0] == 2'h0)
    else $error("page select wrong");
  a_group_d: assert property (@(posedge i_clock) disable iff (!rst_sync)
    (i_reg_direct && i_reg_addr[7:4] == group_d) |=> o_reg_error)
    else $error("direct group d not refused");
  c_twin: cover property (@(posedge i_clock) i_ptr_valid && i_ptr_cmd == crp_ptr_high);
  c_bcd: cover property (@(posedge i_clock) i_op_valid && i_op == crp_op_bcd);
  c_page: cover property (@(posedge i_clock) i_page_valid);
endmodule

// ---- crp_cpu_model.sv ----
// Model of the instruction execution path that issues requests to the core
`timescale 1ns/1ps
module crp_cpu_model
(
  input  wire logic                 i_clock,
  output logic                      o_op_valid,
  output crp_pkg::crp_op_type       o_op,
  output logic                      o_op_word,
  output logic [15:0]               o_op_a,
  output logic [15:0]               o_op_b,
  output logic                      o_carry_in,
  output logic                      o_ptr_valid,
  output crp_pkg::crp_ptr_cmd_type  o_ptr_cmd,
  output logic [4:0]                o_block_index,
  output logic                      o_page_valid,
  output logic [5:0]                o_page_index,
  output logic                      o_reg_wr,
  output logic [7:0]                o_reg_addr,
  output logic [7:0]                o_reg_wdata,
  output logic                      o_reg_direct,
  output logic [3:0]                o_work_index,
  output logic                      o_data_access
);
  import crp_pkg::*;

  initial
  begin
    {o_op_valid, o_op_word, o_op_a, o_op_b, o_carry_in} = '0;
    o_op = crp_op_none;
    {o_ptr_valid, o_block_index, o_page_valid, o_page_index} = '0;
    o_ptr_cmd = crp_ptr_single;
    {o_reg_wr, o_reg_addr, o_reg_wdata, o_reg_direct} = '0;
    {o_work_index, o_data_access} = '0;
  end

  // Each request stands for one taking edge; results are settled 1 ns after it
  task automatic op(input crp_op_type k, input logic w, input logic [15:0] a,
                    input logic [15:0] b);
    @(posedge i_clock);
    o_op_valid <= 1'b1;
    o_op <= k;
    o_op_word <= w;
    o_op_a <= a;
    o_op_b <= b;
    @(posedge i_clock);
    o_op_valid <= 1'b0;
    #1;
  endtask

  task automatic ptr(input crp_ptr_cmd_type c, input logic [4:0] idx);
    @(posedge i_clock);
    o_ptr_valid <= 1'b1;
    o_ptr_cmd <= c;
    o_block_index <= idx;
    @(posedge i_clock);
    o_ptr_valid <= 1'b0;
    #1;
  endtask

  task automatic page(input logic [5:0] idx);
    @(posedge i_clock);
    o_page_valid <= 1'b1;
    o_page_index <= idx;
    @(posedge i_clock);
    o_page_valid <= 1'b0;
    #1;
  endtask

  // High pointer never written as storage
  task automatic reg_access(input logic wr, input logic d, input logic [7:0] a,
                            input logic [7:0] v);
    @(posedge i_clock);
    o_reg_wr <= wr;
    o_reg_direct <= d;
    o_reg_addr <= a;
    o_reg_wdata <= v;
    @(posedge i_clock);
    o_reg_wr <= 1'b0;
    #1;
  endtask

  // Carry input level for later add, subtract and correction requests
  task automatic carry(input logic c);
    @(posedge i_clock);
    o_carry_in <= c;
    @(posedge i_clock);
    #1;
  endtask

  task automatic work(input logic [3:0] idx, input logic dacc);
    @(posedge i_clock);
    o_work_index <= idx;
    o_data_access <= dacc;
    @(posedge i_clock);
    #1;
  endtask
endmodule

// ---- tb_cpu_register_pointing_and_flags.sv ----
// Self-checking bench for the register pointing and flag core
`timescale 1ns/1ps
`define CHK(g, e) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
  end end

module tb_cpu_register_pointing_and_flags;
  import crp_pkg::*;
  logic            clock;
  logic            nrst;
  int              errors      = 0;
  int              check_count = 0;
  logic [7:0]      saved_page;
  wire logic       op_valid, op_word, carry_in, ptr_valid, page_valid, reg_wr;
  wire logic       reg_direct, data_access, bcd_carry, reg_error, use_dp;
  crp_op_type      op;
  crp_ptr_cmd_type ptr_cmd;
  wire logic [15:0] op_a, op_b, result;
  wire logic [4:0] block_index;
  wire logic [5:0] page_in, page_out;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata, work_addr, flags;
  wire logic [3:0] work_index;

  crp_cpu_model cpu (.i_clock(clock), .o_op_valid(op_valid), .o_op(op),
    .o_op_word(op_word), .o_op_a(op_a), .o_op_b(op_b), .o_carry_in(carry_in),
    .o_ptr_valid(ptr_valid), .o_ptr_cmd(ptr_cmd), .o_block_index(block_index),
    .o_page_valid(page_valid), .o_page_index(page_in), .o_reg_wr(reg_wr),
    .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata), .o_reg_direct(reg_direct),
    .o_work_index(work_index), .o_data_access(data_access));

  crp_core DUT (.i_clock(clock), .i_nrst(nrst), .i_op_valid(op_valid), .i_op(op),
    .i_op_word(op_word), .i_op_a(op_a), .i_op_b(op_b), .i_carry_in(carry_in),
    .o_result(result), .o_bcd_carry(bcd_carry), .i_ptr_valid(ptr_valid),
    .i_ptr_cmd(ptr_cmd), .i_block_index(block_index), .i_page_valid(page_valid),
    .i_page_index(page_in), .i_reg_wr(reg_wr), .i_reg_addr(reg_addr),
    .i_reg_wdata(reg_wdata), .i_reg_direct(reg_direct), .o_reg_rdata(reg_rdata),
    .o_reg_error(reg_error), .i_work_index(work_index), .o_work_addr(work_addr),
    .i_data_access(data_access), .o_use_data_pointers(use_dp),
    .o_page_index(page_out), .o_flags(flags));

  task automatic summarize();
    if (errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Run needs about 140 cycles; the 5000-cycle limit leaves wide margin
  initial
  begin
    #200000;
    errors++;
    summarize();
  end

  initial
  begin
    nrst = 1'b0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    cpu.op(crp_op_set_data, 1'b0, 16'h0000, 16'h0000);
    `CHK(flags[0], 1'b1)
    cpu.reg_access(1'b0, 1'b1, 8'he8, 8'h00);
    `CHK(reg_rdata[1:0], 2'h0)
    cpu.reg_access(1'b0, 1'b1, 8'he9, 8'h00);
    `CHK(reg_rdata[1:0], 2'h0)
    cpu.reg_access(1'b0, 1'b1, 8'hea, 8'h00);
    `CHK(reg_rdata[1:0], 2'h0)
    cpu.work(4'h0, 1'b1);
    `CHK(use_dp, 1'b1)
    // Short excursion to code space, put back at once
    cpu.op(crp_op_set_code, 1'b0, 16'h0000, 16'h0000);
    `CHK(flags[0], 1'b0)
    `CHK(use_dp, 1'b0)
    cpu.op(crp_op_set_data, 1'b0, 16'h0000, 16'h0000);
    `CHK(flags[0], 1'b1)
    cpu.work(4'h0, 1'b0);
    `CHK(use_dp, 1'b0)
    cpu.ptr(crp_ptr_single, 5'd3);
    cpu.reg_access(1'b0, 1'b1, 8'he8, 8'h00);
    `CHK(reg_rdata, 8'h10)
    `CHK(work_addr, 8'h10)
    cpu.work(4'hf, 1'b0);
    `CHK(work_addr, 8'h1f)
    cpu.ptr(crp_ptr_low, 5'd5);
    cpu.ptr(crp_ptr_high, 5'd26);
    cpu.reg_access(1'b0, 1'b1, 8'he8, 8'h00);
    `CHK(reg_rdata, 8'h2c)
    cpu.reg_access(1'b0, 1'b1, 8'he9, 8'h00);
    `CHK(reg_rdata, 8'hd4)
    cpu.work(4'h7, 1'b0);
    `CHK(work_addr, 8'h2f)
    cpu.work(4'h8, 1'b0);
    `CHK(work_addr, 8'hd0)
    cpu.work(4'hf, 1'b0);
    `CHK(work_addr, 8'hd7)
    cpu.ptr(crp_ptr_single, 5'd4);
    cpu.reg_access(1'b0, 1'b1, 8'he8, 8'h00);
    `CHK(reg_rdata, 8'h20)
    cpu.reg_access(1'b1, 1'b1, 8'he8, 8'hff);
    cpu.reg_access(1'b0, 1'b1, 8'he8, 8'h00);
    `CHK(reg_rdata, 8'hfc)
    cpu.page(6'h3f);
    `CHK(page_out, 6'h3f)
    cpu.reg_access(1'b0, 1'b1, 8'hea, 8'h00);
    `CHK(reg_rdata, 8'hfc)
    cpu.page(6'h05);
    cpu.reg_access(1'b0, 1'b1, 8'hea, 8'h00);
    `CHK(reg_rdata, 8'h14)
    // Interrupt-style save, change and restore of the page select
    saved_page = reg_rdata;
    cpu.page(6'h2a);
    `CHK(page_out, 6'h2a)
    cpu.reg_access(1'b1, 1'b1, 8'hea, saved_page);
    cpu.reg_access(1'b0, 1'b1, 8'hea, 8'h00);
    `CHK(reg_rdata, 8'h14)
    cpu.reg_access(1'b1, 1'b1, 8'hea, 8'hab);
    cpu.reg_access(1'b0, 1'b1, 8'hea, 8'h00);
    `CHK(reg_rdata, 8'ha8)
    `CHK(page_out, 6'h2a)
    // Software keeps the reserved bit 1 at zero and space select at one
    cpu.reg_access(1'b1, 1'b1, 8'he7, 8'hfd);
    cpu.reg_access(1'b0, 1'b1, 8'he7, 8'h00);
    `CHK(reg_rdata, 8'h3d)
    cpu.op(crp_op_add, 1'b0, 16'h0001, 16'h0001);
    `CHK({flags[5], flags[4], flags[2]}, 3'b000)
    `CHK(flags[3], 1'b0)
    cpu.op(crp_op_add, 1'b0, 16'h007f, 16'h0001);
    `CHK(result[7:0], 8'h80)
    `CHK({flags[5], flags[4], flags[2]}, 3'b111)
    cpu.op(crp_op_none, 1'b0, 16'h0000, 16'h0000);
    `CHK(flags[5:4], 2'b11)
    cpu.op(crp_op_sub, 1'b0, 16'h0080, 16'h0001);
    `CHK(result[7:0], 8'h7f)
    `CHK({flags[5], flags[4], flags[2]}, 3'b011)
    `CHK(flags[3], 1'b1)
    cpu.op(crp_op_add, 1'b1, 16'h7fff, 16'h0001);
    `CHK(result, 16'h8000)
    `CHK(flags[5:4], 2'b11)
    cpu.op(crp_op_sub, 1'b1, 16'h8000, 16'h0001);
    `CHK(flags[5:4], 2'b01)
    cpu.op(crp_op_logic, 1'b0, 16'h0080, 16'h00ff);
    `CHK(flags[5:4], 2'b10)
    cpu.op(crp_op_other, 1'b0, 16'h0000, 16'h0000);
    `CHK(flags[5:4], 2'b00)
    cpu.op(crp_op_add, 1'b0, 16'h0015, 16'h0027);
    `CHK(result[7:0], 8'h3c)
    `CHK(flags[3], 1'b0)
    cpu.op(crp_op_bcd, 1'b0, 16'h003c, 16'h0000);
    `CHK(result[7:0], 8'h42)
    `CHK(bcd_carry, 1'b0)
    cpu.op(crp_op_sub, 1'b0, 16'h0042, 16'h0015);
    `CHK(flags[2], 1'b1)
    cpu.op(crp_op_bcd, 1'b0, 16'h002d, 16'h0000);
    `CHK(result[7:0], 8'h27)
    cpu.op(crp_op_add, 1'b0, 16'h0099, 16'h0001);
    `CHK(flags[2], 1'b0)
    cpu.op(crp_op_bcd, 1'b0, 16'h009a, 16'h0000);
    `CHK(result[7:0], 8'h00)
    `CHK(bcd_carry, 1'b1)
    cpu.carry(1'b1);
    cpu.op(crp_op_add, 1'b0, 16'h000f, 16'h0000);
    `CHK(result[7:0], 8'h10)
    `CHK(flags[2], 1'b1)
    cpu.carry(1'b0);
    cpu.reg_access(1'b0, 1'b1, 8'hd3, 8'h00);
    `CHK(reg_error, 1'b1)
    cpu.reg_access(1'b0, 1'b0, 8'hd3, 8'h00);
    `CHK(reg_error, 1'b0)
    cpu.reg_access(1'b0, 1'b1, 8'he6, 8'h00);
    `CHK(reg_rdata, 8'h00)
    // Second reset in mid-run while the model is idle
    @(posedge clock);
    nrst <= 1'b0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(flags, 8'h00)
    cpu.op(crp_op_set_data, 1'b0, 16'h0000, 16'h0000);
    `CHK(flags[0], 1'b1)
    cpu.reg_access(1'b0, 1'b1, 8'he8, 8'h00);
    `CHK(reg_rdata[1:0], 2'h0)
    cpu.reg_access(1'b0, 1'b1, 8'hea, 8'h00);
    `CHK(reg_rdata[1:0], 2'h0)
    summarize();
  end
endmodule
